// file: hdl/rts_sequencer.sv
// reset and start-up time-out sequencer for the core
`timescale 1ns/100ps
// Summary of operation
// - power-up holds reset for longer of 96 ms and 1024 oscillator periods
// - start-up timer only in crystal modes; other modes wake without delay
// - time-out counting starts at first rising edge of master clear
// - timeout and powerdown flags encode the reset or wake-up cause
// - every reset event outside an interrupt wake-up wait loads program counter with the reset vector
// - status bits 1111, 1110, 1101, 1100 by reset cause
// - interrupt wake-up loads pc+1; status 1110 or 1010 by interrupt disable
// - enabled interrupt wake runs next instruction, then the vector
// - master clear or watchdog while running skip start-up timer
// - start-up timer counts oscillator pulses once amplitude is valid
// - on power-up both timers start together once master clear is high
module rts_sequencer
    import rts_pkg::*;
#(
    parameter int POWERUP_CYCLES = rts_pkg::RTS_POWERUP_DELAY_TIMER_CYCLES
) (
    input wire logic CLOCK,
    input wire logic NRST,
    input wire logic MASTER_CLEAR_PIN,
    input wire logic OSC_INPUT_PIN,
    input wire logic OSC_AMPLITUDE_OK,
    input wire rts_pkg::rts_osc_mode_type OSC_MODE,
    input wire logic WATCHDOG_RESET,
    input wire logic SLEEP_INSTR,
    input wire logic WAKE_INTERRUPT,
    input wire logic WATCHDOG_CLEAR_INSTR,
    input wire logic GLOBAL_INTERRUPT_DISABLE,
    input wire logic [rts_pkg::RTS_PC_W-1:0] PROGRAM_COUNTER,
    output logic CORE_RESET,
    output logic SLEEPING,
    output logic PC_LOAD,
    output logic [rts_pkg::RTS_PC_W-1:0] PC_LOAD_VALUE,
    output logic [3:0] CPU_STATUS_BITS,
    output logic WATCHDOG_TIMEOUT_FLAG,
    output logic POWERDOWN_FLAG,
    output logic OSCILLATOR_STARTUP_TIMER,
    output logic INTERRUPT_VECTOR_NEXT
);
    import rts_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        rts_state_type state;
        logic master_clear_pin_s1;
        logic master_clear_pin_s2;
        logic master_clear_pin_prev;
        logic osc_s1;
        logic osc_s2;
        logic osc_prev;
        logic amp_s1;
        logic amp_s2;
        logic core_reset;
        logic sleeping;
        logic need_powerup_delay_timer;
        logic need_ost;
        logic osc_event;
        logic wake;
        logic powerup_delay_timer_start;
        logic ost_start;
        logic pc_load;
        logic [RTS_PC_W-1:0] pc_value;
        logic [RTS_PC_W-1:0] pc_saved;
        logic [1:0] status_hi;
        logic to_flag;
        logic pd_flag;
        logic vec_next;
    } rts_seq_reg_type;

    localparam rts_seq_reg_type RTS_SEQ_RESET = '{
        state: RTS_ST_HOLD,
        core_reset: RTS_FLAG_SET,
        need_powerup_delay_timer: RTS_FLAG_SET,
        osc_event: RTS_FLAG_SET,
        status_hi: RTS_STATUS_HI_SET,
        to_flag: RTS_FLAG_SET,
        pd_flag: RTS_FLAG_SET,
        default: '0
    };
    localparam logic [RTS_POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST =
        RTS_POWERUP_DELAY_TIMER_W'(POWERUP_CYCLES - 1);
    localparam logic [RTS_OST_W-1:0] OST_LAST =
        RTS_OST_W'(RTS_OST_PERIODS - 1);

    rts_seq_reg_type r_reg;
    rts_seq_reg_type r_next;
    logic powerup_delay_timer_done;
    logic ost_done;
    logic crystal;
    logic master_clear_pin_rise;
    logic ost_step;
    logic timers_done;

    // ---------------------------------------------------------------
    // timers
    // ---------------------------------------------------------------
    // power-up delay steps every clock of the fixed time base
    rts_timer #(.W(RTS_POWERUP_DELAY_TIMER_W), .LAST(POWERUP_DELAY_TIMER_LAST)) u_powerup_delay_timer (
        .clk(CLOCK),
        .nrst(NRST),
        .start(r_reg.powerup_delay_timer_start),
        .step(1'b1),
        .done(powerup_delay_timer_done)
    );

    rts_timer #(.W(RTS_OST_W), .LAST(OST_LAST)) u_ost (
        .clk(CLOCK),
        .nrst(NRST),
        .start(r_reg.ost_start),
        .step(ost_step),
        .done(ost_done)
    );

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        crystal = (OSC_MODE == RTS_MODE_CRYSTAL) ||
            (OSC_MODE == RTS_MODE_LOW_FREQ_CRYSTAL);
        master_clear_pin_rise = r_reg.master_clear_pin_s2 && !r_reg.master_clear_pin_prev;
        // counting waits for a valid swing on the oscillator input
        ost_step = r_reg.osc_s2 && !r_reg.osc_prev && r_reg.amp_s2;
        timers_done = !r_reg.powerup_delay_timer_start && !r_reg.ost_start &&
            (!r_reg.need_powerup_delay_timer || powerup_delay_timer_done) &&
            (!r_reg.need_ost || ost_done);
        r_next = r_reg;
        r_next.master_clear_pin_s1 = MASTER_CLEAR_PIN;
        r_next.master_clear_pin_s2 = r_reg.master_clear_pin_s1;
        r_next.master_clear_pin_prev = r_reg.master_clear_pin_s2;
        r_next.osc_s1 = OSC_INPUT_PIN;
        r_next.osc_s2 = r_reg.osc_s1;
        r_next.osc_prev = r_reg.osc_s2;
        r_next.amp_s1 = OSC_AMPLITUDE_OK;
        r_next.amp_s2 = r_reg.amp_s1;
        r_next.pc_load = 1'b0;
        r_next.powerup_delay_timer_start = 1'b0;
        r_next.ost_start = 1'b0;
        r_next.vec_next = 1'b0;
        unique case (r_reg.state)
            RTS_ST_HOLD: begin
                r_next.core_reset = 1'b1;
                if (master_clear_pin_rise) begin
                    // the timers that are needed start in the same cycle
                    r_next.state = RTS_ST_TIMING;
                    r_next.powerup_delay_timer_start = r_reg.need_powerup_delay_timer;
                    r_next.need_ost = r_reg.osc_event && crystal;
                    r_next.ost_start = r_reg.osc_event && crystal;
                end
            end
            RTS_ST_TIMING: begin
                if (!r_reg.master_clear_pin_s2 && !r_reg.wake) begin
                    // a new low on the pin restarts the whole wait, except after a sleep watchdog reset, where it drops the start-up timer, and in a wake-up wait, where it is ignored
                    r_next.state = RTS_ST_HOLD;
                end else if (timers_done) begin
                    r_next.state = RTS_ST_RUN;
                    r_next.core_reset = 1'b0;
                    r_next.sleeping = 1'b0;
                    r_next.need_powerup_delay_timer = 1'b0;
                    r_next.need_ost = 1'b0;
                    r_next.osc_event = 1'b0;
                    r_next.wake = 1'b0;
                    r_next.pc_load = 1'b1;
                    if (r_reg.wake) begin
                        r_next.pc_value =
                            r_reg.pc_saved + RTS_PC_STEP;
                        r_next.vec_next = !r_reg.status_hi[0];
                    end else begin
                        r_next.pc_value = RTS_RESET_VECTOR;
                    end
                end
            end
            RTS_ST_RUN: begin
                if (!r_reg.master_clear_pin_s2) begin
                    r_next.state = RTS_ST_HOLD;
                    r_next.core_reset = 1'b1;
                    r_next.osc_event = 1'b0;
                    r_next.need_powerup_delay_timer = 1'b0;
                    r_next.status_hi = RTS_STATUS_HI_SET;
                    r_next.to_flag = RTS_FLAG_SET;
                    r_next.pd_flag = RTS_FLAG_SET;
                end else if (WATCHDOG_RESET) begin
                    r_next.state = RTS_ST_TIMING;
                    r_next.core_reset = 1'b1;
                    r_next.osc_event = 1'b0;
                    r_next.need_powerup_delay_timer = 1'b0;
                    r_next.need_ost = 1'b0;
                    r_next.status_hi = RTS_STATUS_HI_SET;
                    r_next.to_flag = RTS_FLAG_CLR;
                    r_next.pd_flag = RTS_FLAG_SET;
                end else if (SLEEP_INSTR) begin
                    r_next.state = RTS_ST_SLEEP;
                    r_next.sleeping = 1'b1;
                    r_next.pc_saved = PROGRAM_COUNTER;
                    r_next.to_flag = RTS_FLAG_SET;
                    r_next.pd_flag = RTS_FLAG_CLR;
                end else if (WATCHDOG_CLEAR_INSTR) begin
                    r_next.to_flag = RTS_FLAG_SET;
                    r_next.pd_flag = RTS_FLAG_SET;
                end
            end
            RTS_ST_SLEEP: begin
                // pin reset outranks watchdog, watchdog outranks wake
                if (!r_reg.master_clear_pin_s2) begin
                    r_next.state = RTS_ST_HOLD;
                    r_next.core_reset = 1'b1;
                    r_next.osc_event = 1'b1;
                    r_next.status_hi = RTS_STATUS_HI_SET;
                    r_next.to_flag = RTS_FLAG_SET;
                    r_next.pd_flag = RTS_FLAG_CLR;
                end else if (WATCHDOG_RESET) begin
                    r_next.state = RTS_ST_TIMING;
                    r_next.core_reset = 1'b1;
                    r_next.need_ost = crystal;
                    r_next.ost_start = crystal;
                    r_next.status_hi = RTS_STATUS_HI_SET;
                    r_next.to_flag = RTS_FLAG_CLR;
                    r_next.pd_flag = RTS_FLAG_CLR;
                end else if (WAKE_INTERRUPT) begin
                    r_next.state = RTS_ST_TIMING;
                    r_next.wake = 1'b1;
                    r_next.need_ost = crystal;
                    r_next.ost_start = crystal;
                    r_next.status_hi =
                        {1'b1, GLOBAL_INTERRUPT_DISABLE};
                    r_next.to_flag = RTS_FLAG_SET;
                    r_next.pd_flag = RTS_FLAG_CLR;
                end
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!NRST) begin
            r_reg <= RTS_SEQ_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign CORE_RESET = r_reg.core_reset;
    assign SLEEPING = r_reg.sleeping;
    assign PC_LOAD = r_reg.pc_load;
    assign PC_LOAD_VALUE = r_reg.pc_value;
    assign CPU_STATUS_BITS = {r_reg.status_hi, r_reg.to_flag, r_reg.pd_flag};
    assign WATCHDOG_TIMEOUT_FLAG = r_reg.to_flag;
    assign POWERDOWN_FLAG = r_reg.pd_flag;
    assign OSCILLATOR_STARTUP_TIMER = r_reg.need_ost;
    assign INTERRUPT_VECTOR_NEXT = r_reg.vec_next;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    sequence wdt_in_run_s;
        r_reg.state == RTS_ST_RUN && r_reg.master_clear_pin_s2 && WATCHDOG_RESET;
    endsequence
    sequence quick_release_s;
        r_reg.state == RTS_ST_TIMING && !r_reg.need_ost ##1
        r_reg.state == RTS_ST_RUN && PC_LOAD;
    endsequence

    powerup_hold_a: assert property (
        r_reg.need_powerup_delay_timer && !powerup_delay_timer_done && r_reg.state == RTS_ST_TIMING
        |=> CORE_RESET)
        else $error("core left reset before power-up delay expired");
    ost_mode_a: assert property (
        $rose(OSCILLATOR_STARTUP_TIMER) |-> $past(crystal))
        else $error("start-up timer used outside crystal modes");
    master_clear_pin_edge_a: assert property (
        r_reg.powerup_delay_timer_start |-> $past(master_clear_pin_rise))
        else $error("time-out began without a master clear rising edge");
    wdt_flags_a: assert property (
        wdt_in_run_s |=> CPU_STATUS_BITS == 4'h0d)
        else $error("watchdog reset while running set wrong flags");
    reset_vector_a: assert property (
        PC_LOAD && !$past(r_reg.wake) |-> PC_LOAD_VALUE == RTS_RESET_VECTOR)
        else $error("reset did not load the reset vector");
    wake_pc_a: assert property (
        PC_LOAD && $past(r_reg.wake)
        |-> PC_LOAD_VALUE == $past(r_reg.pc_saved) + RTS_PC_STEP)
        else $error("interrupt wake-up did not load pc plus one");
    vector_next_a: assert property (
        INTERRUPT_VECTOR_NEXT |-> PC_LOAD && CPU_STATUS_BITS == 4'h0a)
        else $error("vector request without enabled interrupt wake-up");
    wdt_no_ost_a: assert property (
        wdt_in_run_s |=> quick_release_s)
        else $error("running watchdog reset waited on start-up timer");
    ost_count_a: assert property (
        $rose(ost_done) |-> $past(r_reg.amp_s2))
        else $error("start-up timer counted without valid amplitude");
    release_a: assert property (
        $fell(CORE_RESET) |->
        (!$past(r_reg.need_ost) || $past(ost_done)) &&
        (!$past(r_reg.need_powerup_delay_timer) || $past(powerup_delay_timer_done)))
        else $error("core released with a timer still running");
endmodule

// file: pkg/rts_pkg.sv
// constants and types shared by the reset time-out sequencer
package rts_pkg;

    // ---------------------------------------------------------------
    // clock and delays
    // ---------------------------------------------------------------
    localparam int RTS_CLK_MHZ = 100;
    localparam int RTS_POWERUP_DELAY_TIMER_TIME_MS = 96;
    localparam int RTS_US_PER_MS = 1000;
    // power-up delay counted on the fixed 100 MHz time base
    localparam int RTS_POWERUP_DELAY_TIMER_CYCLES = RTS_POWERUP_DELAY_TIMER_TIME_MS * RTS_US_PER_MS
        * RTS_CLK_MHZ;
    localparam int RTS_POWERUP_DELAY_TIMER_W = 24;
    // oscillator start-up delay in oscillator periods
    localparam int RTS_OST_PERIODS = 1024;
    localparam int RTS_OST_W = 10;

    // ---------------------------------------------------------------
    // program counter and status values
    // ---------------------------------------------------------------
    localparam int RTS_PC_W = 16;
    localparam logic [RTS_PC_W-1:0] RTS_RESET_VECTOR = 16'h0000;
    localparam logic [RTS_PC_W-1:0] RTS_PC_STEP = 16'h0001;
    localparam logic [1:0] RTS_STATUS_HI_SET = 2'h3;
    localparam logic RTS_FLAG_SET = 1'h1;
    localparam logic RTS_FLAG_CLR = 1'h0;

    // ---------------------------------------------------------------
    // oscillator configuration and sequencer states
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        RTS_MODE_LOW_FREQ_CRYSTAL = 2'h0,
        RTS_MODE_CRYSTAL = 2'h1,
        RTS_MODE_EXTERNAL_CLOCK = 2'h2,
        RTS_MODE_RESISTOR_CAP = 2'h3
    } rts_osc_mode_type;

    typedef enum logic [1:0] {
        RTS_ST_HOLD = 2'h0,
        RTS_ST_TIMING = 2'h1,
        RTS_ST_RUN = 2'h3,
        RTS_ST_SLEEP = 2'h2
    } rts_state_type;

endpackage

// file: hdl/rts_timer.sv
// up-counting delay timer with restart and step enable
`timescale 1ns/100ps
module rts_timer #(
    parameter int W = 10,
    parameter logic [W-1:0] LAST = '1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic step,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } rts_timer_reg_type;

    rts_timer_reg_type r_reg;
    rts_timer_reg_type r_next;

    always_comb begin
        r_next = r_reg;
        if (start) begin
            r_next = '0;
        end else if (step && !r_reg.done) begin
            if (r_reg.cnt == LAST) begin
                r_next.done = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign done = r_reg.done;

    // done only rises on the last counted step
    timer_expiry_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(r_reg.done) |-> $past(step) && $past(r_reg.cnt) == LAST)
        else $error("timer expired without reaching its last count");
endmodule

// file: dv/rts_pin_model.sv
// master clear circuit and crystal oscillator as seen at the pins
`timescale 1ns/100ps
module rts_pin_model (
    input wire logic clk,
    input wire logic press,
    input wire logic amp_en,
    output logic master_clear_pin_n,
    output logic osc,
    output logic amp_ok
);
    logic [1:0] div_reg = 2'h0;

    // ---------------------------------------------------------------
    // pins
    // ---------------------------------------------------------------
    // pull-up on the pin: released means high, never the last level
    assign master_clear_pin_n = ~press;
    assign amp_ok = amp_en;
    // period of four clocks keeps the crystal slower than half the clock
    always @(posedge clk) begin
        div_reg <= div_reg + 2'h1;
    end
    assign osc = div_reg[1];
endmodule

// file: dv/rts_sequencer_tb.sv
// self-checking bench for the reset time-out sequencer
`timescale 1ns/100ps
module rts_sequencer_tb;
    import rts_pkg::*;
    typedef struct packed {
        logic [15:0] pc;
        logic [3:0] st;
        logic ivn;
    } rts_note_type;
    localparam int POWERUP_DELAY_TIMER = 6000;
    logic CLOCK = 1'b0;
    logic NRST = 1'b0;
    logic press = 1'b1;
    logic amp_en = 1'b0;
    logic MASTER_CLEAR_PIN, OSC_INPUT_PIN, OSC_AMPLITUDE_OK;
    rts_osc_mode_type OSC_MODE = RTS_MODE_CRYSTAL;
    logic WATCHDOG_RESET = 1'b0;
    logic SLEEP_INSTR = 1'b0;
    logic WAKE_INTERRUPT = 1'b0;
    logic WATCHDOG_CLEAR_INSTR = 1'b0;
    logic GLOBAL_INTERRUPT_DISABLE = 1'b1;
    logic [15:0] PROGRAM_COUNTER = 16'h0000;
    logic CORE_RESET, SLEEPING, PC_LOAD, WATCHDOG_TIMEOUT_FLAG;
    logic POWERDOWN_FLAG, OSCILLATOR_STARTUP_TIMER, INTERRUPT_VECTOR_NEXT;
    logic [15:0] PC_LOAD_VALUE;
    logic [3:0] CPU_STATUS_BITS;
    rts_note_type notes[$];
    rts_note_type mon_n;
    int err_count = 0;
    int samples_checked = 0;
    int seed = 32'h4a63;
    logic [15:0] rpc;
    logic gl;
    logic oscillator_startup_timer;

    initial begin
        forever #5 CLOCK = ~CLOCK;
    end

    rts_pin_model u_rts_pin_model (.clk(CLOCK), .press(press),
        .amp_en(amp_en), .master_clear_pin_n(MASTER_CLEAR_PIN),
        .osc(OSC_INPUT_PIN), .amp_ok(OSC_AMPLITUDE_OK));

    rts_sequencer #(.POWERUP_CYCLES(POWERUP_DELAY_TIMER)) u_rts_sequencer (
        .CLOCK(CLOCK), .NRST(NRST), .MASTER_CLEAR_PIN(MASTER_CLEAR_PIN),
        .OSC_INPUT_PIN(OSC_INPUT_PIN), .OSC_AMPLITUDE_OK(OSC_AMPLITUDE_OK),
        .OSC_MODE(OSC_MODE), .WATCHDOG_RESET(WATCHDOG_RESET),
        .SLEEP_INSTR(SLEEP_INSTR), .WAKE_INTERRUPT(WAKE_INTERRUPT),
        .WATCHDOG_CLEAR_INSTR(WATCHDOG_CLEAR_INSTR),
        .GLOBAL_INTERRUPT_DISABLE(GLOBAL_INTERRUPT_DISABLE),
        .PROGRAM_COUNTER(PROGRAM_COUNTER), .CORE_RESET(CORE_RESET),
        .SLEEPING(SLEEPING), .PC_LOAD(PC_LOAD),
        .PC_LOAD_VALUE(PC_LOAD_VALUE), .CPU_STATUS_BITS(CPU_STATUS_BITS),
        .WATCHDOG_TIMEOUT_FLAG(WATCHDOG_TIMEOUT_FLAG),
        .POWERDOWN_FLAG(POWERDOWN_FLAG),
        .OSCILLATOR_STARTUP_TIMER(OSCILLATOR_STARTUP_TIMER),
        .INTERRUPT_VECTOR_NEXT(INTERRUPT_VECTOR_NEXT));

    // ---------------------------------------------------------------
    // checking and closing
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // every load pulse takes the oldest note and compares outputs
    always @(posedge CLOCK) begin
        if (PC_LOAD === 1'b1) begin
            mon_n = notes.size() > 0 ? notes.pop_front() : 21'h1f_ffff;
            chk("load value", mon_n.pc, PC_LOAD_VALUE);
            chk("status flags vector", {9'h000, mon_n.st, mon_n.st[1:0],
                mon_n.ivn}, {9'h000, CPU_STATUS_BITS, WATCHDOG_TIMEOUT_FLAG,
                POWERDOWN_FLAG, INTERRUPT_VECTOR_NEXT});
            // the release edge drops reset together with the load pulse
            chk("core reset at load", 16'h0000,
                {15'h0000, CORE_RESET});
        end
    end

    // ---------------------------------------------------------------
    // drivers
    // ---------------------------------------------------------------
    // bounded wait for the release; lo and hi bound the cycles taken
    task automatic wait_load(input logic exp_ost, input logic exp_rst,
            input int lo, input int hi);
        int k;
        logic seen;
        logic held;
        seen = 1'b0;
        held = 1'b0;
        k = 0;
        while (PC_LOAD !== 1'b1 && k <= hi + 8) begin
            @(posedge CLOCK);
            k++;
            seen = seen | OSCILLATOR_STARTUP_TIMER;
            held = held | CORE_RESET;
        end
        if (k > hi + 8) begin
            err_count++;
            $display("[ERR] release expected by %0d seen none", hi);
            complete_run();
        end else begin
            chk("start-up timer use", {15'h0000, exp_ost},
                {15'h0000, seen});
            chk("core reset hold", {15'h0000, exp_rst},
                {15'h0000, held});
            samples_checked++;
            if (k < lo || k > hi) begin
                err_count++;
                $display("[ERR] release cycles expected %0d seen %0d", lo, k);
            end
        end
    endtask

    task automatic pulse(input int w);
        @(posedge CLOCK);
        case (w)
            0: WATCHDOG_RESET <= 1'b1;
            1: SLEEP_INSTR <= 1'b1;
            2: WAKE_INTERRUPT <= 1'b1;
            default: WATCHDOG_CLEAR_INSTR <= 1'b1;
        endcase
        @(posedge CLOCK);
        WATCHDOG_RESET <= 1'b0;
        SLEEP_INSTR <= 1'b0;
        WAKE_INTERRUPT <= 1'b0;
        WATCHDOG_CLEAR_INSTR <= 1'b0;
    endtask

    task automatic sleep_in();
        rpc = 16'($random(seed));
        @(posedge CLOCK);
        PROGRAM_COUNTER <= rpc;
        pulse(1);
        repeat (2) @(posedge CLOCK);
        chk("sleep flags", 16'h0006, {13'h0000, SLEEPING,
            WATCHDOG_TIMEOUT_FLAG, POWERDOWN_FLAG});
    endtask

    task automatic master_clear_pin(input int low);
        @(posedge CLOCK);
        press <= 1'b1;
        repeat (low) @(posedge CLOCK);
        press <= 1'b0;
    endtask

    // the pin stays low well after power-on so counting must wait for it
    task automatic por(input int amp_wait, input int lo);
        @(posedge CLOCK);
        NRST <= 1'b0;
        press <= 1'b1;
        amp_en <= 1'b0;
        repeat (8) @(posedge CLOCK);
        NRST <= 1'b1;
        repeat (100) @(posedge CLOCK);
        press <= 1'b0;
        notes.push_back({16'h0000, 4'hf, 1'b0});
        fork
            begin
                repeat (amp_wait) @(posedge CLOCK);
                amp_en <= 1'b1;
            end
            wait_load(1'b1, 1'b1, lo, lo + 20);
        join
        $display("power-on with amplitude wait %0d done", amp_wait);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        por(3000, 7092);
        notes.push_back({16'h0000, 4'hd, 1'b0});
        pulse(0);
        wait_load(1'b0, 1'b1, 0, 6);
        notes.push_back({16'h0000, 4'hf, 1'b0});
        master_clear_pin(20);
        wait_load(1'b0, 1'b1, 0, 8);
        $display("running resets done");
        sleep_in();
        notes.push_back({16'h0000, 4'he, 1'b0});
        master_clear_pin(20);
        wait_load(1'b1, 1'b1, 4088, 4120);
        sleep_in();
        notes.push_back({16'h0000, 4'hc, 1'b0});
        pulse(0);
        wait_load(1'b1, 1'b1, 4088, 4120);
        $display("sleep resets done");
        for (int m = 0; m < 4; m++) begin
            @(posedge CLOCK);
            OSC_MODE <= rts_osc_mode_type'(m);
            // both interrupt-disable levels are seen whatever the seed
            if (m == 0) begin
                gl = 1'($random(seed));
            end else begin
                gl = ~gl;
            end
            GLOBAL_INTERRUPT_DISABLE <= gl;
            sleep_in();
            notes.push_back({rpc + 16'h0001, 1'b1, gl, 2'h2, ~gl});
            pulse(2);
            oscillator_startup_timer = (m < 2);
            wait_load(oscillator_startup_timer, 1'b0, oscillator_startup_timer ? 4088 : 0,
                oscillator_startup_timer ? 4120 : 6);
            $display("wake in mode %0d done", m);
        end
        pulse(3);
        repeat (2) @(posedge CLOCK);
        chk("clear flags", 16'h0003, {14'h0000, WATCHDOG_TIMEOUT_FLAG,
            POWERDOWN_FLAG});
        OSC_MODE <= RTS_MODE_CRYSTAL;
        por(0, POWERUP_DELAY_TIMER + 1);
        complete_run();
    end
endmodule
